// ### design/dctt_map.svh
// register offsets, field positions, reset values and counts of the debug comparator and trace block
`ifndef DCTT_MAP_SVH
`define DCTT_MAP_SVH
`define DCTT_OFS_MAIN      6'h20
`define DCTT_OFS_STATUS    6'h21
`define DCTT_OFS_COUNT     6'h22
`define DCTT_OFS_UNLOCK    6'h23
`define DCTT_OFS_TRACE     6'h24
`define DCTT_OFS_CTL       6'h28
`define DCTT_OFS_ADDR_HI   6'h29
`define DCTT_OFS_ADDR_MID  6'h2A
`define DCTT_OFS_ADDR_LO   6'h2B
`define DCTT_OFS_DATA_HI   6'h2C
`define DCTT_OFS_DATA_LO   6'h2D
`define DCTT_OFS_MASK_HI   6'h2E
`define DCTT_OFS_MASK_LO   6'h2F
`define DCTT_MAIN_ARM      7
`define DCTT_MAIN_ALIGN    5
`define DCTT_MAIN_BANK     0
`define DCTT_CTL_EN        0
`define DCTT_CTL_RWV       2
`define DCTT_CTL_RWE       3
`define DCTT_CTL_COP       4
`define DCTT_CTL_TAG       5
`define DCTT_CTL_SZV       6
`define DCTT_CTL_SZE       7
`define DCTT_CTL_RANGE     7
`define DCTT_RST_MAIN      8'h00
`define DCTT_RST_CTL       8'h00
`define DCTT_MID_LINES     8'h20
`define DCTT_ARMED_READ    8'h00
`define DCTT_QUEUE_DEPTH   3'h4
`endif

// ### design/dctt_pkg.sv
// types of the debug comparator and trace block
package dctt_pkg;
    typedef enum logic [2:0] {
        DCTT_SEQ_IDLE  = 3'b001,
        DCTT_SEQ_ARMED = 3'b010,
        DCTT_SEQ_FINAL = 3'b100
    } dctt_seq_e;
    typedef enum logic [1:0] {
        DCTT_ALIGN_BEGIN = 2'b00,
        DCTT_ALIGN_MID   = 2'b01,
        DCTT_ALIGN_END   = 2'b10
    } dctt_align_e;
    typedef struct packed {
        logic [7:0]        main;
        logic [3:0][7:0]   ctl;
        logic [3:0][23:0]  addr;
        logic [1:0][15:0]  dcmp;
        logic [1:0][15:0]  dmsk;
        dctt_seq_e         seq;
        logic [7:0]        cnt;
        logic [6:0]        wptr;
        logic [6:0]        rptr;
        logic [2:0]        bidx;
        logic [7:0]        post;
        logic [3:0]        tagq;
        logic [2:0]        qcnt;
        logic [7:0]        rdata;
    } dctt_state_s;
endpackage

// ### design/dctt_top.sv
// debug comparators, trace buffer read-out and opcode tagging with breakpoint generation
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "dctt_map.svh"
module dctt_top #(
    parameter int DEPTH = 64
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        bus_valid_in,
    input  wire logic [23:0] bus_addr_in,
    input  wire logic [15:0] bus_data_in,
    input  wire logic        bus_write_in,
    input  wire logic        bus_word_in,
    input  wire logic        bus_cop_in,
    input  wire logic        fetch_valid_in,
    input  wire logic [23:0] fetch_addr_in,
    input  wire logic        fetch_cop_in,
    input  wire logic        head_exec_in,
    input  wire logic        queue_flush_in,
    input  wire logic        trace_valid_in,
    input  wire logic [63:0] trace_line_in,
    output logic             tag_hit_out,
    output logic             breakpoint_out,
    output logic             armed_out
);
    import dctt_pkg::*;

    localparam int         AW    = $clog2(DEPTH);
    localparam logic [6:0] PMASK = 7'(DEPTH - 1);
    localparam logic [7:0] FULL  = 8'(DEPTH);

    dctt_state_s st_r;
    dctt_state_s st_nxt;
    logic [63:0] trace_mem [DEPTH];
    logic        trace_we;
    logic        tag_hit;
    logic        bkpt_now;

    // A and C are the full banks; used by both the read and the write decode
    function automatic logic full_bank(input logic [1:0] bank);
        full_bank = ~bank[0];
    endfunction

    // address match of comparator k, exact or as a range pair A..B / C..D
    function automatic logic addr_hit(input dctt_state_s s, input int k, input logic [23:0] a,
                                      input logic word_only);
        logic [23:0] lo;
        logic [23:0] hi;
        logic        rng;
        int          base;
        base = k & 2;
        lo   = s.addr[base];
        hi   = s.addr[base + 1];
        rng  = s.ctl[base + 1][`DCTT_CTL_RANGE];
        if (rng && (k & 1) != 0) begin
            addr_hit = 1'b0; // upper bound of a range makes no match of its own
        end else if (rng && word_only) begin
            addr_hit = (a[23:1] >= lo[23:1]) && (a[23:1] <= hi[23:1]);
        end else if (rng) begin
            addr_hit = (a >= lo) && (a <= hi);
        end else begin
            addr_hit = (a == s.addr[k]);
        end
    endfunction

    // next-state logic: registers, comparators, tag queue, sequencer, trace pointers
    always_comb begin
        logic [1:0]  bank;
        logic [1:0]  align;
        logic        imm_trig;
        logic        tag_push;
        logic        qual;
        logic        tracing;
        logic [2:0]  qleft;
        logic [7:0]  limit;
        logic [6:0]  oldest;
        logic [63:0] line;
        int          di;
        // every local gets a value first so no path leaves a latch behind
        qual     = 1'b0;
        tracing  = 1'b0;
        qleft    = 3'h0;
        limit    = 8'h00;
        oldest   = 7'h00;
        di       = 0;
        st_nxt   = st_r;
        bank     = st_r.main[`DCTT_MAIN_BANK +: 2];
        align    = st_r.main[`DCTT_MAIN_ALIGN +: 2];
        imm_trig = 1'b0;
        tag_push = 1'b0;
        trace_we = 1'b0;
        bkpt_now = 1'b0;
        line     = trace_mem[st_r.rptr[AW-1:0]];
        st_nxt.rdata = 8'h00;

        // comparators: tag select picks tagging or an immediate trigger
        for (int k = 0; k < 4; k++) begin
            di = k >> 1;
            if (st_r.ctl[k][`DCTT_CTL_EN]) begin
                if (st_r.ctl[k][`DCTT_CTL_TAG]) begin
                    // qualifiers are not looked at when tagging
                    if (fetch_valid_in && fetch_cop_in == st_r.ctl[k][`DCTT_CTL_COP]
                        && addr_hit(st_r, k, fetch_addr_in, 1'b1)) begin
                        tag_push = 1'b1;
                    end
                end else begin
                    qual = bus_valid_in && bus_cop_in == st_r.ctl[k][`DCTT_CTL_COP]
                        && addr_hit(st_r, k, bus_addr_in, 1'b0);
                    if (st_r.ctl[k][`DCTT_CTL_RWE] && bus_write_in == st_r.ctl[k][`DCTT_CTL_RWV]) begin
                        qual = 1'b0;
                    end
                    if (full_bank(2'(k))) begin
                        if (st_r.ctl[k][`DCTT_CTL_SZE] && bus_word_in != st_r.ctl[k][`DCTT_CTL_SZV]) begin
                            qual = 1'b0;
                        end
                        if (((bus_data_in ^ st_r.dcmp[di]) & st_r.dmsk[di]) != 16'h0000) begin
                            qual = 1'b0;
                        end
                    end
                    imm_trig = imm_trig | qual;
                end
            end
        end

        // tag queue follows the opcode stream; the head bit is the hit
        tag_hit = head_exec_in && st_r.qcnt != 3'h0 && st_r.tagq[0];
        qleft   = st_r.qcnt;
        if (head_exec_in && st_r.qcnt != 3'h0) begin
            st_nxt.tagq = {1'b0, st_r.tagq[3:1]};
            qleft       = st_r.qcnt - 3'h1;
        end
        st_nxt.qcnt = qleft;
        if (fetch_valid_in && qleft < `DCTT_QUEUE_DEPTH) begin
            st_nxt.tagq[qleft[1:0]] = tag_push;
            st_nxt.qcnt             = qleft + 3'h1;
        end
        if (queue_flush_in) begin
            st_nxt.tagq = 4'h0;
            st_nxt.qcnt = 3'h0;
        end

        // tracing window depends on alignment and sequencer state
        tracing = (st_r.seq == DCTT_SEQ_ARMED && align != DCTT_ALIGN_BEGIN)
               || (st_r.seq == DCTT_SEQ_FINAL && align != DCTT_ALIGN_END);
        trace_we = tracing && trace_valid_in;
        if (trace_we) begin
            st_nxt.wptr = (st_r.wptr + 7'h01) & PMASK;
            if (st_r.cnt != FULL) begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
        limit = (align == DCTT_ALIGN_BEGIN) ? FULL : `DCTT_MID_LINES;

        // state sequencer
        case (st_r.seq)
            DCTT_SEQ_ARMED: begin
                if (imm_trig || tag_hit) begin
                    if (align == DCTT_ALIGN_END) begin
                        bkpt_now   = 1'b1;
                        st_nxt.seq = DCTT_SEQ_IDLE;
                    end else begin
                        st_nxt.seq  = DCTT_SEQ_FINAL;
                        st_nxt.post = 8'h00;
                    end
                end
            end
            DCTT_SEQ_FINAL: begin
                if (trace_we) begin
                    st_nxt.post = st_r.post + 8'h01;
                    if (st_r.post + 8'h01 == limit) begin
                        bkpt_now   = 1'b1;
                        st_nxt.seq = DCTT_SEQ_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.seq = st_r.seq;
            end
        endcase

        // register writes
        if (reg_wr_in) begin
            if (reg_addr_in == `DCTT_OFS_MAIN) begin
                st_nxt.main = {1'b0, reg_wdata_in[6:0]};
                if (!reg_wdata_in[`DCTT_MAIN_ARM]) begin
                    st_nxt.seq = DCTT_SEQ_IDLE;
                end else if (st_r.seq == DCTT_SEQ_IDLE) begin
                    // arming starts a fresh session
                    st_nxt.seq  = DCTT_SEQ_ARMED;
                    st_nxt.cnt  = 8'h00;
                    st_nxt.wptr = 7'h00;
                    st_nxt.post = 8'h00;
                end
            end else if (reg_addr_in == `DCTT_OFS_UNLOCK) begin
                oldest = (st_r.cnt == FULL) ? st_r.wptr : ((st_r.wptr - st_r.cnt[6:0]) & PMASK);
                st_nxt.rptr = oldest;
                st_nxt.bidx = 3'h0;
            end else if (reg_addr_in == `DCTT_OFS_CTL) begin
                st_nxt.ctl[bank] = reg_wdata_in;
            end else if (reg_addr_in == `DCTT_OFS_ADDR_HI) begin
                st_nxt.addr[bank][23:16] = reg_wdata_in;
            end else if (reg_addr_in == `DCTT_OFS_ADDR_MID) begin
                st_nxt.addr[bank][15:8] = reg_wdata_in;
            end else if (reg_addr_in == `DCTT_OFS_ADDR_LO) begin
                st_nxt.addr[bank][7:0] = reg_wdata_in;
            end else if (full_bank(bank)) begin
                if (reg_addr_in == `DCTT_OFS_DATA_HI) begin
                    st_nxt.dcmp[bank[1]][15:8] = reg_wdata_in;
                end else if (reg_addr_in == `DCTT_OFS_DATA_LO) begin
                    st_nxt.dcmp[bank[1]][7:0] = reg_wdata_in;
                end else if (reg_addr_in == `DCTT_OFS_MASK_HI) begin
                    st_nxt.dmsk[bank[1]][15:8] = reg_wdata_in;
                end else if (reg_addr_in == `DCTT_OFS_MASK_LO) begin
                    st_nxt.dmsk[bank[1]][7:0] = reg_wdata_in;
                end
            end
        end

        // register reads, data stand in the following cycle only
        if (reg_rd_in) begin
            if (reg_addr_in == `DCTT_OFS_MAIN) begin
                st_nxt.rdata = {st_r.seq != DCTT_SEQ_IDLE, st_r.main[6:0]};
            end else if (reg_addr_in == `DCTT_OFS_STATUS) begin
                st_nxt.rdata = {5'h00, st_r.seq};
            end else if (reg_addr_in == `DCTT_OFS_COUNT) begin
                st_nxt.rdata = st_r.cnt;
            end else if (reg_addr_in == `DCTT_OFS_TRACE) begin
                if (st_r.seq != DCTT_SEQ_IDLE) begin
                    st_nxt.rdata = `DCTT_ARMED_READ;
                end else begin
                    // byte 0 first so the low word leaves first, shaded bytes included
                    st_nxt.rdata = line[{st_r.bidx, 3'h0} +: 8];
                    st_nxt.bidx  = st_r.bidx + 3'h1;
                    if (st_r.bidx == 3'h7) begin
                        st_nxt.rptr = (st_r.rptr + 7'h01) & PMASK;
                    end
                end
            end else if (reg_addr_in == `DCTT_OFS_CTL) begin
                st_nxt.rdata = full_bank(bank) ? st_r.ctl[bank]
                                               : {st_r.ctl[bank][7], 1'b0, st_r.ctl[bank][5:0]};
            end else if (reg_addr_in == `DCTT_OFS_ADDR_HI) begin
                st_nxt.rdata = st_r.addr[bank][23:16];
            end else if (reg_addr_in == `DCTT_OFS_ADDR_MID) begin
                st_nxt.rdata = st_r.addr[bank][15:8];
            end else if (reg_addr_in == `DCTT_OFS_ADDR_LO) begin
                st_nxt.rdata = st_r.addr[bank][7:0];
            end else if (full_bank(bank)) begin
                if (reg_addr_in == `DCTT_OFS_DATA_HI) begin
                    st_nxt.rdata = st_r.dcmp[bank[1]][15:8];
                end else if (reg_addr_in == `DCTT_OFS_DATA_LO) begin
                    st_nxt.rdata = st_r.dcmp[bank[1]][7:0];
                end else if (reg_addr_in == `DCTT_OFS_MASK_HI) begin
                    st_nxt.rdata = st_r.dmsk[bank[1]][15:8];
                end else if (reg_addr_in == `DCTT_OFS_MASK_LO) begin
                    st_nxt.rdata = st_r.dmsk[bank[1]][7:0];
                end
            end
        end
    end

    // state register; the line counter and write pointer survive reset so a
    // session cut short by reset can still be read back
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_r      <= '0;
            st_r.seq  <= DCTT_SEQ_IDLE;
            st_r.main <= `DCTT_RST_MAIN;
            st_r.ctl  <= {4{`DCTT_RST_CTL}};
            st_r.cnt  <= st_r.cnt;
            st_r.wptr <= st_r.wptr;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // trace storage has no reset at all
    always_ff @(posedge clk_sys_in) begin
        if (ce_in && rst_n_in && trace_we) begin
            trace_mem[st_r.wptr[AW-1:0]] <= trace_line_in;
        end
    end

    // pulses are gated by the enable so a frozen block reports no tag hit or breakpoint; armed_out is not gated
    assign tag_hit_out    = ce_in && rst_n_in && tag_hit;
    assign breakpoint_out = ce_in && rst_n_in && bkpt_now;
    assign armed_out      = st_r.seq != DCTT_SEQ_IDLE;
    assign reg_rdata_out  = st_r.rdata;
endmodule

// ### dv/dctt_checker.sv
// port-level assertions for the debug comparator and trace block
`timescale 1ns/1ns
module dctt_checker (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_rdata_out,
    input  wire logic        head_exec_in,
    input  wire logic        tag_hit_out,
    input  wire logic        breakpoint_out,
    input  wire logic        armed_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] main_r;
    // shadow of the main control byte, since bank and alignment are not visible at the ports
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            main_r <= 8'h00;
        else if (ce_in && reg_wr_in && reg_addr_in == 6'h20)
            main_r <= reg_wdata_in;
    end
    property p_rd_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_bd_zero;
        $past(reg_rd_in && reg_addr_in[5:2] == 4'hB && main_r[0]) |-> reg_rdata_out == 8'h00;
    endproperty
    a_bd_zero: assert property (p_bd_zero) else $error("data byte of B or D not zero");
    property p_bd_bit6;
        $past(reg_rd_in && reg_addr_in == 6'h28 && main_r[0]) |-> !reg_rdata_out[6];
    endproperty
    a_bd_bit6: assert property (p_bd_bit6) else $error("bit 6 of B or D control set");
    property p_armed_trace;
        $past(reg_rd_in && reg_addr_in == 6'h24 && armed_out) |-> reg_rdata_out == 8'h00;
    endproperty
    a_armed_trace: assert property (p_armed_trace) else $error("trace data while armed");
    property p_arm;
        ce_in && reg_wr_in && reg_addr_in == 6'h20 && reg_wdata_in[7] && !armed_out |=> armed_out;
    endproperty
    a_arm: assert property (p_arm) else $error("arming write ignored");
    property p_tag_exec;
        tag_hit_out |-> head_exec_in && ce_in;
    endproperty
    a_tag_exec: assert property (p_tag_exec) else $error("tag hit without head execute");
    property p_bp_disarm;
        breakpoint_out |=> !armed_out;
    endproperty
    a_bp_disarm: assert property (p_bp_disarm) else $error("still armed after breakpoint");
    property p_end_now;
        tag_hit_out && armed_out && main_r[6:5] == 2'b10 |-> breakpoint_out;
    endproperty
    a_end_now: assert property (p_end_now) else $error("end alignment breakpoint late");
endmodule
bind dctt_top dctt_checker i_chk (.clk_sys_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .head_exec_in, .tag_hit_out, .breakpoint_out, .armed_out);

// ### dv/dctt_core_model.sv
// behavioural core bus, instruction queue and trace source facing the block
`timescale 1ns/1ns
module dctt_core_model (
    input  wire logic        clk_sys_in,
    input  wire logic        tag_hit_in,
    input  wire logic        breakpoint_in,
    output logic             bus_valid_out,
    output logic [23:0]      bus_addr_out,
    output logic [15:0]      bus_data_out,
    output logic             fetch_valid_out,
    output logic [23:0]      fetch_addr_out,
    output logic             fetch_cop_out,
    output logic             head_exec_out,
    output logic             trace_valid_out,
    output logic [63:0]      trace_line_out
);
    // released bus address, bus data and fetch address lines carry the inverse of the last value so stale data never looks valid
    initial begin
        bus_valid_out   = 1'b0;
        bus_addr_out    = 24'h000000;
        bus_data_out    = 16'h0000;
        fetch_valid_out = 1'b0;
        fetch_addr_out  = 24'h000000;
        fetch_cop_out   = 1'b0;
        head_exec_out   = 1'b0;
        trace_valid_out = 1'b0;
        trace_line_out  = 64'h0;
    end
    // one word write access on the data bus, breakpoint sampled in its cycle
    task automatic access(input logic [23:0] a, input logic [15:0] d, output logic bp);
        @(posedge clk_sys_in);
        bus_valid_out <= 1'b1;
        bus_addr_out  <= a;
        bus_data_out  <= d;
        @(posedge clk_sys_in);
        bp = breakpoint_in;
        bus_valid_out <= 1'b0;
        bus_addr_out  <= ~a;
        bus_data_out  <= ~d;
    endtask
    // fetch one opcode into an empty queue, then execute it from the head
    task automatic run(input logic [23:0] a, input logic c, output logic hit, output logic bp);
        @(posedge clk_sys_in);
        fetch_valid_out <= 1'b1;
        fetch_addr_out  <= a;
        fetch_cop_out   <= c;
        @(posedge clk_sys_in);
        fetch_valid_out <= 1'b0;
        fetch_addr_out  <= ~a;
        head_exec_out   <= 1'b1;
        @(posedge clk_sys_in);
        hit = tag_hit_in;
        bp = breakpoint_in;
        head_exec_out <= 1'b0;
    endtask
    // n trace lines, byte j of line i is (base + i) ^ j; at counts the lines up to and including the one that broke
    task automatic trace(input int n, input logic [7:0] base, output int at);
        at = 0;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_sys_in);
            if (breakpoint_in)
                at = i;
            trace_valid_out <= (i < n);
            trace_line_out  <= {8{base + 8'(i)}} ^ 64'h0706050403020100;
        end
    endtask
endmodule

// ### dv/testbench.sv
// self-checking testbench of the debug comparator and trace block
`timescale 1ns/1ns
`include "dctt_map.svh"
module testbench;
    localparam int DEPTH = 8;
    logic        clk_sys_in   = 1'b0;
    logic        rst_n_in     = 1'b0;
    logic        ce_in        = 1'b1;
    logic [5:0]  reg_addr_in  = 6'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        bus_valid_in, fetch_valid_in, fetch_cop_in, head_exec_in, trace_valid_in;
    logic [23:0] bus_addr_in, fetch_addr_in;
    logic [15:0] bus_data_in;
    logic [63:0] trace_line_in;
    logic        tag_hit_out, breakpoint_out, armed_out;
    int          n_fail       = 0;
    int          n_compared   = 0;
    int          cycles       = 0;
    // write, word size, main bus and no flush are fixed: the queue only ever holds one entry
    dctt_top #(.DEPTH(DEPTH)) i_dut (.clk_sys_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_valid_in, .bus_addr_in, .bus_data_in,
        .bus_write_in(1'b1), .bus_word_in(1'b1), .bus_cop_in(1'b0), .fetch_valid_in, .fetch_addr_in,
        .fetch_cop_in, .head_exec_in, .queue_flush_in(1'b0), .trace_valid_in, .trace_line_in,
        .tag_hit_out, .breakpoint_out, .armed_out);
    dctt_core_model i_core (.clk_sys_in, .tag_hit_in(tag_hit_out), .breakpoint_in(breakpoint_out),
        .bus_valid_out(bus_valid_in), .bus_addr_out(bus_addr_in), .bus_data_out(bus_data_in),
        .fetch_valid_out(fetch_valid_in), .fetch_addr_out(fetch_addr_in), .fetch_cop_out(fetch_cop_in),
        .head_exec_out(head_exec_in), .trace_valid_out(trace_valid_in), .trace_line_out(trace_line_in));
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a hung handshake ends the run as a failure
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        // look once the answer register has settled, not in its launching time step
        #1;
        chk(nm, reg_rdata_out, exp);
    endtask
    task automatic do_reset();
        rst_n_in <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
    endtask
    initial begin
        logic [7:0] v;
        logic       h;
        logic       b;
        int         at;
        do_reset();
        rdc("unmapped", 6'h25, 8'h00);
        // every bank gets its own pattern first, so shared storage would show on read-back
        for (int k = 0; k < 8; k++) begin
            wr(`DCTT_OFS_MAIN, 8'(k % 4));
            for (int o = 0; o < 8; o++) begin
                v = {2'(k % 4), 3'b000, 3'(o)};
                if (k < 4)
                    wr(6'h28 + 6'(o), v);
                if (k[0] && o > 3)
                    v = 8'h00;
                if (k[0] && o == 0)
                    v[6] = 1'b0;
                if (k > 3)
                    rdc("window", 6'h28 + 6'(o), v);
            end
        end
        // mid alignment with the direction qualifier set but ignored
        wr(`DCTT_OFS_MAIN, 8'h00);
        wr(6'h28, 8'h2D);
        wr(6'h29, 8'h00);
        wr(6'h2A, 8'h12);
        wr(6'h2B, 8'h34);
        wr(`DCTT_OFS_MAIN, 8'hA0);
        rdc("armed trace", `DCTT_OFS_TRACE, 8'h00);
        i_core.run(24'h001236, 1'b0, h, b);
        chk("untagged opcode", {7'h00, h}, 8'h00);
        i_core.run(24'h001234, 1'b0, h, b);
        chk("mid tag hit", {6'h00, h, b}, 8'h02);
        i_core.trace(40, 8'h00, at);
        chk("mid lines", 8'(at), 8'h20);
        rdc("mid disarmed", `DCTT_OFS_MAIN, 8'h20);
        // begin alignment traces only after the hit
        wr(`DCTT_OFS_MAIN, 8'h80);
        i_core.run(24'h001234, 1'b0, h, b);
        chk("begin tag hit", {6'h00, h, b}, 8'h02);
        rdc("final state", `DCTT_OFS_STATUS, 8'h04);
        i_core.trace(DEPTH + 2, 8'h00, at);
        chk("begin lines", 8'(at), 8'(DEPTH));
        // end alignment on a coprocessor opcode breaks at once
        wr(6'h28, 8'h31);
        wr(`DCTT_OFS_MAIN, 8'hC0);
        i_core.run(24'h001234, 1'b1, h, b);
        chk("end tag hit", {6'h00, h, b}, 8'h03);
        // untagged data compare with the low byte masked off
        wr(6'h28, 8'h01);
        wr(6'h2A, 8'h20);
        wr(6'h2B, 8'h00);
        wr(6'h2C, 8'h12);
        wr(6'h2D, 8'h34);
        wr(6'h2E, 8'hFF);
        wr(6'h2F, 8'h00);
        wr(`DCTT_OFS_MAIN, 8'hC0);
        i_core.trace(11, 8'h40, at);
        i_core.access(24'h002000, 16'h13FF, b);
        chk("data mismatch", {7'h00, b}, 8'h00);
        i_core.access(24'h002000, 16'h12AB, b);
        chk("masked match", {7'h00, b}, 8'h01);
        // eleven lines wrapped the buffer, so the oldest kept line is the fourth
        do_reset();
        rdc("count kept", `DCTT_OFS_COUNT, 8'(DEPTH));
        wr(`DCTT_OFS_UNLOCK, 8'h00);
        for (int n = 0; n < 16; n++)
            rdc("trace byte", `DCTT_OFS_TRACE, (8'h43 + 8'(n / 8)) ^ 8'(n % 8));
        conclude();
    end
endmodule
